/* core/spiee_pkg.sv */
// Shared constants of the serial EEPROM command and protection logic
package spiee_pkg;
  // Instruction codes (bit 3 is ignored, upper nibble must be zero)
  localparam logic [2:0] OP_SET_LATCH   = 3'h6;
  localparam logic [2:0] OP_CLEAR_LATCH = 3'h4;
  localparam logic [2:0] OP_READ_STATUS = 3'h5;
  localparam logic [2:0] OP_WRITE_STAT  = 3'h1;
  localparam logic [2:0] OP_ARRAY_READ  = 3'h3;
  localparam logic [2:0] OP_ARRAY_WRITE = 3'h2;
  localparam logic [3:0] OP_UPPER       = 4'h0;

  // Status register field positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WEL_BIT  = 1;
  localparam int ST_BP_LO    = 2;
  localparam int ST_BP_HI    = 3;
  localparam int ST_PEN_BIT  = 7;
  localparam logic [7:0] ST_BUSY_VALUE = 8'hFF;

  // Power-up values of the nonvolatile protect bits
  localparam logic [1:0] BP_RESET  = 2'h0;
  localparam logic       PEN_RESET = 1'b0;

  // Address and page geometry
  localparam int ADDR_W_DEF  = 15;
  localparam int PAGE_BITS   = 6;
  localparam int PAGE_BYTES  = 64;

  // Protection levels
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QTR  = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;

  // Self-timed write cycle
  localparam int T_WC_MS   = 5;
  localparam int CLK_MHZ   = 250;
  localparam int WC_CYCLES = T_WC_MS * CLK_MHZ * 1000;
  localparam int WC_CNT_W  = 21;
endpackage

/* core/spiee_pin_if.sv */
// Synchronised pin level with its edge pulses
interface spiee_pin_if;
  logic lvl;
  logic rise;
  logic fall;
  modport drv (output lvl, output rise, output fall);
  modport use_p (input lvl, input rise, input fall);
endinterface

/* core/spiee_pin_sync.sv */
// Two-flop pin synchroniser with edge detection
module spiee_pin_sync #(
  parameter logic INIT = 1'b0          // Level assumed at reset
) (
  input  wire logic   sys_clk_i,      // System clock
  input  wire logic   rst_i,          // Synchronous reset
  input  wire logic   pin_i,          // Asynchronous pin
  spiee_pin_if.drv    pin_o           // Level and edges
);
  logic meta_r, sync_r, last_r;
  logic meta_nxt, sync_nxt, last_nxt;

  // Only sync_r reads meta_r; edges come from the settled stages
  always_comb begin
    meta_nxt = pin_i;
    sync_nxt = meta_r;
    last_nxt = sync_r;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta_r <= INIT;
      sync_r <= INIT;
      last_r <= INIT;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
    end
  end

  assign pin_o.lvl  = sync_r;
  assign pin_o.rise = sync_r & ~last_r;
  assign pin_o.fall = ~sync_r & last_r;
endmodule

/* core/spiee_core.sv */
// Serial EEPROM command decoder, protection logic and write-cycle timer
module spiee_core #(
  parameter int ADDR_W = spiee_pkg::ADDR_W_DEF,   // 14 or 15 address bits
  parameter int WC_CYC = spiee_pkg::WC_CYCLES     // Write cycle length
) (
  input  wire logic              sys_clk_i,    // System clock
  input  wire logic              rst_i,        // Synchronous reset, high
  input  wire logic              cs_n_i,       // Chip select pin, low
  input  wire logic              sck_i,        // Serial clock pin
  input  wire logic              si_i,         // Serial data in pin
  input  wire logic              hold_n_i,     // Pause pin, low
  input  wire logic              wp_n_i,       // Write protect pin, low
  output logic                   so_o,         // Serial data out
  output logic                   so_oe_o,      // Serial out drive enable
  output logic [ADDR_W-1:0]      mem_addr_o,   // Array address
  input  wire logic [7:0]        mem_rdata_i,  // Array read data
  output logic                   mem_we_o,     // Array write strobe
  output logic [7:0]             mem_wdata_o,  // Array write data
  output logic                   busy_o        // Write cycle running
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_CMD = 3'h1, ST_ADDR = 3'h3, ST_RD = 3'h2,
    ST_WR = 3'h6, ST_SRD = 3'h7, ST_SWR = 3'h5, ST_IGN = 3'h4
  } spiee_state_e;

  localparam int PB = spiee_pkg::PAGE_BITS;

  spiee_pin_if cs_s ();
  spiee_pin_if sck_s ();
  spiee_pin_if si_s ();
  spiee_pin_if hold_s ();
  spiee_pin_if wp_s ();

  // Every pin passes two flops before any logic looks at it
  spiee_pin_sync #(.INIT(1'b1)) u_cs   (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
                                        .pin_i(cs_n_i), .pin_o(cs_s));
  spiee_pin_sync #(.INIT(1'b0)) u_sck  (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
                                        .pin_i(sck_i), .pin_o(sck_s));
  spiee_pin_sync #(.INIT(1'b0)) u_si   (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
                                        .pin_i(si_i), .pin_o(si_s));
  spiee_pin_sync #(.INIT(1'b1)) u_hold (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
                                        .pin_i(hold_n_i), .pin_o(hold_s));
  spiee_pin_sync #(.INIT(1'b1)) u_wp   (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
                                        .pin_i(wp_n_i), .pin_o(wp_s));

  spiee_state_e            state_r, state_nxt;
  logic [2:0]              bit_cnt_r, bit_cnt_nxt;
  logic [6:0]              shift_r, shift_nxt;
  logic [7:0]              out_r, out_nxt;
  logic                    so_r, so_nxt;
  logic                    so_en_r, so_en_nxt;
  logic                    paused_r, paused_nxt;
  logic                    load_r, load_nxt;
  logic                    is_rd_r, is_rd_nxt;
  logic                    adr_hi_r, adr_hi_nxt;
  logic [ADDR_W-1:0]       addr_r, addr_nxt;
  logic                    wel_r, wel_nxt;
  logic [1:0]              bp_r, bp_nxt;
  logic                    pen_r, pen_nxt;
  logic [7:0]              sr_new_r, sr_new_nxt;
  logic                    sr_pend_r, sr_pend_nxt;
  logic [PB:0]             widx_r, widx_nxt;
  logic                    busy_r, busy_nxt;
  logic                    kind_st_r, kind_st_nxt;
  logic [spiee_pkg::WC_CNT_W-1:0] wc_cnt_r, wc_cnt_nxt;
  logic [spiee_pkg::PAGE_BYTES-1:0] valid_r, valid_nxt;
  logic [7:0]              page_mem [spiee_pkg::PAGE_BYTES];

  logic       rise_ok, fall_ok, byte_done, hw_prot, page_prot;
  logic       buf_we;
  logic [7:0] byte_v, status_v;

  // Pins pass through the same two-flop delay, so their order is kept
  assign rise_ok   = sck_s.rise & ~paused_r & (state_r != ST_IDLE);
  assign fall_ok   = sck_s.fall & ~paused_r & (state_r != ST_IDLE);
  assign byte_v    = {shift_r, si_s.lvl};
  assign byte_done = rise_ok & (bit_cnt_r == 3'h7);
  assign hw_prot   = ~wp_s.lvl & pen_r;

  // Protected range against the top address bits of the page base
  always_comb begin
    case (bp_r)
      spiee_pkg::BP_NONE: page_prot = 1'b0;
      spiee_pkg::BP_QTR:  page_prot = &addr_r[ADDR_W-1 -: 2];
      spiee_pkg::BP_HALF: page_prot = addr_r[ADDR_W-1];
      default:            page_prot = 1'b1;
    endcase
  end

  // Status byte; all ones while programming
  always_comb begin
    status_v = '0;
    status_v[spiee_pkg::ST_PEN_BIT]  = pen_r;
    status_v[spiee_pkg::ST_BP_HI]    = bp_r[1];
    status_v[spiee_pkg::ST_BP_LO]    = bp_r[0];
    status_v[spiee_pkg::ST_WEL_BIT]  = wel_r;
    status_v[spiee_pkg::ST_BUSY_BIT] = busy_r;
    if (busy_r)
      status_v = spiee_pkg::ST_BUSY_VALUE;
  end

  // Serial protocol, latch and write-cycle sequencing
  always_comb begin
    state_nxt   = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt   = shift_r;
    out_nxt     = out_r;
    so_nxt      = so_r;
    so_en_nxt   = so_en_r;
    load_nxt    = 1'b0;
    is_rd_nxt   = is_rd_r;
    adr_hi_nxt  = adr_hi_r;
    addr_nxt    = addr_r;
    wel_nxt     = wel_r;
    bp_nxt      = bp_r;
    pen_nxt     = pen_r;
    sr_new_nxt  = sr_new_r;
    sr_pend_nxt = sr_pend_r;
    valid_nxt   = valid_r;
    busy_nxt    = busy_r;
    kind_st_nxt = kind_st_r;
    wc_cnt_nxt  = wc_cnt_r;
    widx_nxt    = widx_r;
    buf_we      = 1'b0;
    // Pause state follows hold only while the serial clock is low; a select fall clears it at any clock level
    paused_nxt  = sck_s.lvl ? paused_r : ~hold_s.lvl;

    if (rise_ok) begin
      shift_nxt   = byte_v[6:0];
      bit_cnt_nxt = bit_cnt_r + 3'h1;
    end
    if (fall_ok && (state_r == ST_RD || state_r == ST_SRD)) begin
      so_nxt    = out_r[7];
      out_nxt   = {out_r[6:0], 1'b0};
      so_en_nxt = 1'b1;
    end
    if (load_r)
      out_nxt = (state_r == ST_SRD) ? status_v : mem_rdata_i;

    case (state_r)
      ST_CMD: begin
        if (byte_done) begin
          state_nxt = ST_IGN;
          if (byte_v[7:4] == spiee_pkg::OP_UPPER) begin
            if (byte_v[2:0] == spiee_pkg::OP_READ_STATUS) begin
              state_nxt = ST_SRD;
              load_nxt  = 1'b1;
            end else if (!busy_r) begin
              case (byte_v[2:0])
                spiee_pkg::OP_SET_LATCH:   wel_nxt = 1'b1;
                spiee_pkg::OP_CLEAR_LATCH: wel_nxt = 1'b0;
                spiee_pkg::OP_WRITE_STAT:
                  if (wel_r && !hw_prot)
                    state_nxt = ST_SWR;
                spiee_pkg::OP_ARRAY_READ: begin
                  state_nxt = ST_ADDR;
                  is_rd_nxt = 1'b1;
                end
                spiee_pkg::OP_ARRAY_WRITE:
                  if (wel_r) begin
                    state_nxt = ST_ADDR;
                    is_rd_nxt = 1'b0;
                    valid_nxt = '0;
                  end
                default: state_nxt = ST_IGN;
              endcase
            end
          end
        end
      end
      ST_ADDR: begin
        if (byte_done) begin
          // Upper don't-care bits drop out of the narrow address
          addr_nxt   = ADDR_W'({addr_r, byte_v});
          adr_hi_nxt = 1'b1;
          if (adr_hi_r) begin
            state_nxt = is_rd_r ? ST_RD : ST_WR;
            load_nxt  = is_rd_r;
          end
        end
      end
      ST_RD: begin
        if (byte_done) begin
          addr_nxt = addr_r + ADDR_W'(1);
          load_nxt = 1'b1;
        end
      end
      ST_SRD: begin
        if (byte_done)
          load_nxt = 1'b1;
      end
      ST_WR: begin
        if (byte_done) begin
          buf_we = 1'b1;
          valid_nxt[addr_r[PB-1:0]] = 1'b1;
          addr_nxt[PB-1:0] = addr_r[PB-1:0] + PB'(1);
        end
      end
      ST_SWR: begin
        if (byte_done) begin
          sr_new_nxt  = byte_v;
          sr_pend_nxt = 1'b1;
          state_nxt   = ST_IGN;
        end
      end
      default: ;
    endcase

    // Deselect ends every sequence and may launch programming
    if (cs_s.rise) begin
      state_nxt = ST_IDLE;
      so_en_nxt = 1'b0;
      if (!busy_r && bit_cnt_r == 3'h0) begin
        if (sr_pend_r && wel_r && !hw_prot) begin
          busy_nxt    = 1'b1;
          kind_st_nxt = 1'b1;
          wc_cnt_nxt  = '0;
        end else if (state_r == ST_WR && (|valid_r) && !page_prot) begin
          busy_nxt    = 1'b1;
          kind_st_nxt = 1'b0;
          wc_cnt_nxt  = '0;
          widx_nxt    = '0;
        end
      end
      sr_pend_nxt = 1'b0;
    end else if (cs_s.fall) begin
      state_nxt   = ST_CMD;
      bit_cnt_nxt = '0;
      adr_hi_nxt  = 1'b0;
      so_en_nxt   = 1'b0;
      paused_nxt  = 1'b0;
      sr_pend_nxt = 1'b0;
    end

    // Self-timed cycle; buffered page goes out in its first cycles
    if (busy_r) begin
      wc_cnt_nxt = wc_cnt_r + spiee_pkg::WC_CNT_W'(1);
      if (!widx_r[PB])
        widx_nxt = widx_r + (PB+1)'(1);
      if (wc_cnt_r == spiee_pkg::WC_CNT_W'(WC_CYC - 1)) begin
        busy_nxt = 1'b0;
        wel_nxt  = 1'b0;
        if (kind_st_r) begin
          bp_nxt  = {sr_new_r[spiee_pkg::ST_BP_HI], sr_new_r[spiee_pkg::ST_BP_LO]};
          pen_nxt = sr_new_r[spiee_pkg::ST_PEN_BIT];
        end
      end
    end
  end

  // Protocol and protection registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= '0;
      shift_r   <= '0;
      out_r     <= '0;
      so_r      <= 1'b0;
      so_en_r   <= 1'b0;
      paused_r  <= 1'b0;
      load_r    <= 1'b0;
      is_rd_r   <= 1'b0;
      adr_hi_r  <= 1'b0;
      addr_r    <= '0;
      wel_r     <= 1'b0;
      bp_r      <= spiee_pkg::BP_RESET;
      pen_r     <= spiee_pkg::PEN_RESET;
      sr_new_r  <= '0;
      sr_pend_r <= 1'b0;
      valid_r   <= '0;
      busy_r    <= 1'b0;
      kind_st_r <= 1'b0;
      wc_cnt_r  <= '0;
      widx_r    <= '0;
    end else begin
      state_r   <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r   <= shift_nxt;
      out_r     <= out_nxt;
      so_r      <= so_nxt;
      so_en_r   <= so_en_nxt;
      paused_r  <= paused_nxt;
      load_r    <= load_nxt;
      is_rd_r   <= is_rd_nxt;
      adr_hi_r  <= adr_hi_nxt;
      addr_r    <= addr_nxt;
      wel_r     <= wel_nxt;
      bp_r      <= bp_nxt;
      pen_r     <= pen_nxt;
      sr_new_r  <= sr_new_nxt;
      sr_pend_r <= sr_pend_nxt;
      valid_r   <= valid_nxt;
      busy_r    <= busy_nxt;
      kind_st_r <= kind_st_nxt;
      wc_cnt_r  <= wc_cnt_nxt;
      widx_r    <= widx_nxt;
    end
  end

  // Page buffer; later bytes at a wrapped slot overwrite earlier ones
  always_ff @(posedge sys_clk_i) begin
    if (buf_we)
      page_mem[addr_r[PB-1:0]] <= byte_v;
  end

  // Array side: page drained slot by slot at the start of the cycle
  assign mem_addr_o  = busy_r ? {addr_r[ADDR_W-1:PB], widx_r[PB-1:0]} : addr_r;
  assign mem_we_o    = busy_r & ~kind_st_r & ~widx_r[PB] & valid_r[widx_r[PB-1:0]];
  assign mem_wdata_o = page_mem[widx_r[PB-1:0]];
  assign busy_o      = busy_r;

  // Output floats when deselected, paused or not in a read
  assign so_o    = so_r;
  assign so_oe_o = so_en_r & ~paused_r & (state_r == ST_RD || state_r == ST_SRD);
endmodule

/* dv/spiee_checker.sv */
// Port-level assertions for the serial EEPROM core
module spiee_checker #(
  parameter int ADDR_W = 15,  // Address bits
  parameter int WC_CYC = 200  // Write cycle length
) (
  input wire logic              sys_clk_i,    // System clock
  input wire logic              rst_i,        // Synchronous reset
  input wire logic              cs_n_i,       // Chip select, low
  input wire logic              sck_i,        // Serial clock
  input wire logic              si_i,         // Serial data in
  input wire logic              hold_n_i,     // Pause, low
  input wire logic              wp_n_i,       // Write protect, low
  input wire logic              so_o,         // Serial data out
  input wire logic              so_oe_o,      // Serial out enable
  input wire logic [ADDR_W-1:0] mem_addr_o,   // Array address
  input wire logic [7:0]        mem_rdata_i,  // Array read data
  input wire logic              mem_we_o,     // Array write strobe
  input wire logic [7:0]        mem_wdata_o,  // Array write data
  input wire logic              busy_o        // Write cycle running
);
  timeunit 1ns;
  timeprecision 1ps;
  int busy_cnt_r;
  int busy_cnt_nxt;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // Length of the current busy run; a counter keeps the long bound cheap
  always_comb begin
    busy_cnt_nxt = (rst_i || !busy_o) ? 0 : busy_cnt_r + 1;
  end
  always_ff @(posedge sys_clk_i) begin
    busy_cnt_r <= busy_cnt_nxt;
  end

  property p_desel_float;
    cs_n_i [*5] |-> !so_oe_o;
  endproperty
  a_desel_float: assert property (p_desel_float) else $error("so driven while deselected");
  property p_pause_float;
    (!hold_n_i && !sck_i) [*5] |-> !so_oe_o;
  endproperty
  a_pause_float: assert property (p_pause_float) else $error("so driven while paused");
  property p_we_busy;
    mem_we_o |-> busy_o;
  endproperty
  a_we_busy: assert property (p_we_busy) else $error("array write outside write cycle");
  property p_busy_start;
    $rose(busy_o) |-> cs_n_i && !$past(cs_n_i, 8);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("write cycle without select rise");
  property p_busy_min;
    $rose(busy_o) |=> busy_o [*8];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("write cycle cut short");
  property p_busy_len;
    $fell(busy_o) |-> busy_cnt_r >= WC_CYC - 1 && busy_cnt_r <= WC_CYC + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_we_window;
    mem_we_o |-> busy_cnt_r < 65;
  endproperty
  a_we_window: assert property (p_we_window) else $error("write strobe beyond page slots");
  property p_we_page;
    busy_o && $past(busy_o) |->
      mem_addr_o[ADDR_W-1:6] == $past(mem_addr_o[ADDR_W-1:6]);
  endproperty
  a_we_page: assert property (p_we_page) else $error("page bits moved in write cycle");

  // Main scenarios reached
  c_busy: cover property ($rose(busy_o));
  c_we: cover property (mem_we_o);
  c_so: cover property ($rose(so_oe_o));
endmodule

bind spiee_core spiee_checker #(.ADDR_W(ADDR_W), .WC_CYC(WC_CYC)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i),
  .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
  .mem_addr_o(mem_addr_o), .mem_rdata_i(mem_rdata_i), .mem_we_o(mem_we_o),
  .mem_wdata_o(mem_wdata_o), .busy_o(busy_o));

/* dv/spiee_master.sv */
// Behavioural serial master in clock mode 0 facing the EEPROM core
module spiee_master (
  input  wire logic sys_clk_i,  // System clock
  input  wire logic so_i,       // Serial data from device
  input  wire logic so_oe_i,    // Device drives so
  output logic      cs_n_o,     // Chip select, low
  output logic      sck_o,      // Serial clock
  output logic      si_o,       // Serial data to device
  output logic      hold_n_o    // Pause, low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 20;  // 160 ns serial period

  // Clock idles low between frames
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b1;
    hold_n_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // Every sequence opens with a select fall
  task automatic sel();
    wt(1);
    cs_n_o = 1'b0;
    wt(10);
  endtask
  // Rise while clock is low after the last bit; released data line flips
  task automatic desel();
    wt(10);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    wt(30);
  endtask
  // MSB first; data set while clock low, reply taken at the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_o = tx[i];
      wt(HALF);
      sck_o = 1'b1;
      rx[i] = so_oe_i ? so_i : 1'bz;
      wt(HALF);
      sck_o = 1'b0;
    end
  endtask
  // Pause and resume, both while the clock is low
  task automatic pause(input int n);
    hold_n_o = 1'b0;
    wt(n);
    hold_n_o = 1'b1;
    wt(4);
  endtask
endmodule

/* dv/testbench.sv */
// Self-checking bench for the serial EEPROM command and protect core
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WC = 1000;  // Shortened write cycle, still longer than one status poll
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        wp_n = 1'b1;
  logic        cs_n, sck, si, hold_n, so, so_oe, mem_we, busy;
  logic [14:0] mem_addr;
  logic [7:0]  mem_wdata, mem_rdata, rx;
  logic [7:0]  mem [0:32767];
  int          bad_count = 0;
  int          n_compared = 0;

  always #2 sys_clk = ~sys_clk;
  // Array model: combinational read, strobed write
  assign mem_rdata = mem[mem_addr];
  always @(posedge sys_clk) if (mem_we) mem[mem_addr] <= mem_wdata;

  spiee_master m (.sys_clk_i(sys_clk), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n),
    .sck_o(sck), .si_o(si), .hold_n_o(hold_n));
  spiee_core #(.ADDR_W(15), .WC_CYC(WC)) dut (.sys_clk_i(sys_clk), .rst_i(rst),
    .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so),
    .so_oe_o(so_oe), .mem_addr_o(mem_addr), .mem_rdata_i(mem_rdata), .mem_we_o(mem_we),
    .mem_wdata_o(mem_wdata), .busy_o(busy));

  function automatic logic [7:0] pat(input logic [14:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    m.sel();
    m.xfer(op, rx);
    m.desel();
  endtask
  task automatic status(input logic [7:0] exp);
    m.sel();
    m.xfer(8'h05, rx);
    m.xfer(8'h00, rx);
    m.desel();
    check(rx, exp, "status");
  endtask
  task automatic wr_arr(input logic [15:0] a, input logic [7:0] d, input int n);
    m.sel();
    m.xfer(8'h02, rx);
    m.xfer(a[15:8], rx);
    m.xfer(a[7:0], rx);
    for (int i = 0; i < n; i++) m.xfer(d + 8'(i), rx);
    m.desel();
  endtask
  task automatic wr_stat(input logic [7:0] d);
    m.sel();
    m.xfer(8'h01, rx);
    m.xfer(d, rx);
    m.desel();
  endtask
  // Bounded wait for the self-timed cycle to end
  task automatic idle(input logic started);
    int k;
    k = 0;
    check({7'h00, busy}, {7'h00, started}, "cycle start");
    while (busy !== 1'b0 && k < 2 * WC) begin
      @(negedge sys_clk);
      k++;
    end
    check({7'h00, busy}, 8'h00, "cycle end");
  endtask

  task automatic t_latch();
    status(8'h00);
    cmd(8'h0E);
    status(8'h02);
    cmd(8'h0C);
    status(8'h00);
    $display("latch test done");
  endtask
  // Page wrap, busy status, latch clear at end; bit 15 ignored
  task automatic t_page();
    cmd(8'h06);
    wr_arr(16'h813E, 8'hA0, 3);
    status(8'hFF);
    idle(1'b1);
    status(8'h00);
    check(mem[15'h013E], 8'hA0, "slot 3E");
    check(mem[15'h013F], 8'hA1, "slot 3F");
    check(mem[15'h0100], 8'hA2, "slot wrap");
    wr_arr(16'h0200, 8'h11, 1);
    idle(1'b0);
    check(mem[15'h0200], pat(15'h0200), "no latch");
    $display("page test done");
  endtask
  // Read across the top address with a pause between bytes
  task automatic t_read();
    m.sel();
    m.xfer(8'h0B, rx);
    m.xfer(8'hFF, rx);
    m.xfer(8'hFF, rx);
    m.xfer(8'h00, rx);
    check(rx, pat(15'h7FFF), "read top");
    m.pause(60);
    m.xfer(8'h00, rx);
    m.desel();
    check(rx, pat(15'h0000), "read wrap");
    m.sel();
    m.xfer(8'h13, rx);
    m.xfer(8'h05, rx);
    m.desel();
    check(rx, 8'hZZ, "bad opcode");
    $display("read test done");
  endtask
  task automatic t_protect();
    cmd(8'h06);
    wr_stat(8'h84);
    idle(1'b1);
    status(8'h84);
    cmd(8'h06);
    wr_arr(16'h7000, 8'h33, 1);
    idle(1'b0);
    check(mem[15'h7000], pat(15'h7000), "protected");
    wr_arr(16'h1000, 8'h44, 1);
    idle(1'b1);
    check(mem[15'h1000], 8'h44, "open block");
    @(negedge sys_clk) wp_n = 1'b0;
    cmd(8'h06);
    wr_stat(8'h00);
    idle(1'b0);
    status(8'h86);
    @(negedge sys_clk) wp_n = 1'b1;
    wr_stat(8'h00);
    idle(1'b1);
    status(8'h00);
    $display("protect test done");
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = pat(15'(i));
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    repeat (5) @(negedge sys_clk);
    t_latch();
    t_page();
    t_read();
    t_protect();
    print_verdict();
  end
  // Watchdog: the tests need about 22k cycles, this allows 50k
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
endmodule
